// ==== shared/pdss_pkg.sv ====
// pdss_pkg: register map, field layout and carrier types of the pwm dead-time stage
// assumes the core clock equals the oscillator and software uses axi4-lite
package pdss_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_DTC = 8'h00;
    localparam logic [7:0] ADDR_TBC = 8'h04;
    localparam logic [7:0] ADDR_PER = 8'h08;
    localparam logic [7:0] ADDR_DUTY0 = 8'h0C;
    localparam logic [7:0] ADDR_DUTY1 = 8'h10;
    localparam logic [7:0] ADDR_DUTY2 = 8'h14;
    localparam logic [7:0] ADDR_DUTY3 = 8'h18;
    localparam logic [7:0] ADDR_PAIR_MODE_BIT = 8'h1C;
    localparam logic [7:0] ADDR_OVS = 8'h20;
    localparam logic [7:0] ADDR_OVV = 8'h24;
    localparam logic [7:0] ADDR_STAT = 8'h28;
    // ==========================================================
    // field positions
    localparam int DTC_PS_LO = 6;
    localparam int TBC_EN = 0;
    localparam int TBC_MODE_LO = 2;
    localparam int TBC_PS_LO = 4;
    localparam int TBC_IE = 6;
    localparam int STAT_DONE = 0;
    localparam int STAT_PINS_LO = 8;
    localparam int STAT_TMR_LO = 16;
    // ==========================================================
    // reset values and codes
    localparam logic [7:0] RST_DTC = 8'h00;
    localparam logic [7:0] RST_OVS = 8'hFF;
    localparam logic [7:0] RST_OVV = 8'h00;
    localparam logic [3:0] RST_PAIR_MODE_BIT = 4'h0;
    localparam logic [1:0] MODE_SINGLE = 2'b01;
    localparam logic [1:0] PS_DIV2 = 2'b00;
    localparam logic [1:0] Q_LAST = 2'd3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ==========================================================
    // carrier types
    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } pdss_axi_in_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pdss_axi_out_t;
    typedef struct packed {
        logic cmp;
        logic eff;
        logic [5:0] cnt;
        logic [1:0] psc;
        logic [1:0] ph;
        logic busy;
        logic blank;
        logic odd;
        logic even;
    } pdss_pair_t;
endpackage

// ==== design/pdss_stage.sv ====
// pdss_stage: edge-aligned time base, four duty compares, dead-time pairs,
// overrides and single-pulse control behind an axi4-lite slave
// assumes CORE_CLK is the oscillator; q phases are derived internally
`timescale 1ns/1ps
module pdss_stage (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire pdss_pkg::pdss_axi_in_t AXI_IN,
    output pdss_pkg::pdss_axi_out_t AXI_OUT,
    output logic [7:0] PWM_PINS,
    output logic PULSE_DONE_IRQ
);
    import pdss_pkg::*;

    typedef struct packed {
        logic [7:0] dtc;
        logic en;
        logic en_q;
        logic [1:0] mode;
        logic [1:0] tbps;
        logic ie;
        logic [11:0] per;
        logic [3:0][13:0] duty;
        logic [3:0] pair_mode_bit;
        logic [7:0] ovs;
        logic [7:0] ovv;
        logic done;
        logic irq;
        logic [1:0] q;
        logic [5:0] tdiv;
        logic [11:0] tmr;
        pdss_pair_t [3:0] pr;
        logic [7:0] pins;
        logic bpend;
        logic rpend;
        pdss_axi_out_t axi;
    } pdss_state_t;

    pdss_state_t s_reg;
    pdss_state_t s_next;
    logic wr_go;
    logic rd_go;
    logic tb_tick;
    logic per_hit;
    logic start;
    logic dt_tick;
    logic [31:0] wd;
    logic [31:0] rd;

    // ==========================================================
    // helpers
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
            begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // time-base divide in instruction cycles, minus one
    function automatic logic [5:0] tb_limit(input logic [1:0] ps);
        case (ps)
            2'b00: return 6'h00;
            2'b01: return 6'h03;
            2'b10: return 6'h0F;
            default: return 6'h3F;
        endcase
    endfunction

    // dead-time divide in instruction cycles, minus one (osc/4 is one cycle)
    function automatic logic [1:0] dt_limit(input logic [1:0] ps);
        case (ps)
            2'b10: return 2'd1;
            2'b11: return 2'd3;
            default: return 2'd0;
        endcase
    endfunction

    // ==========================================================
    // next-state logic
    always_comb
    begin
        s_next = s_reg;
        rd = 32'h0000_0000;
        wd = 32'h0000_0000;
        dt_tick = 1'b0;
        // bus handshake: ready pulses one cycle, answer the cycle after
        s_next.axi.awready = 1'b0;
        s_next.axi.wready = 1'b0;
        s_next.axi.arready = 1'b0;
        s_next.bpend = 1'b0;
        s_next.rpend = 1'b0;
        if (s_reg.axi.bvalid && AXI_IN.bready)
        begin
            s_next.axi.bvalid = 1'b0;
        end
        if (s_reg.axi.rvalid && AXI_IN.rready)
        begin
            s_next.axi.rvalid = 1'b0;
        end
        if (s_reg.bpend)
        begin
            s_next.axi.bvalid = 1'b1;
        end
        if (s_reg.rpend)
        begin
            s_next.axi.rvalid = 1'b1;
        end
        wr_go = AXI_IN.awvalid && AXI_IN.wvalid && !s_reg.axi.bvalid && !s_reg.bpend
            && !s_reg.axi.awready;
        rd_go = AXI_IN.arvalid && !s_reg.axi.rvalid && !s_reg.rpend && !s_reg.axi.arready;
        s_next.irq = 1'b0;
        // register writes
        if (wr_go)
        begin
            s_next.axi.awready = 1'b1;
            s_next.axi.wready = 1'b1;
            s_next.bpend = 1'b1;
            s_next.axi.bresp = RESP_OKAY;
            case (AXI_IN.awaddr)
                ADDR_DTC:
                begin
                    wd = wmerge({24'h00_0000, s_reg.dtc}, AXI_IN.wdata, AXI_IN.wstrb);
                    s_next.dtc = wd[7:0];
                    for (int i = 0; i < 4; i++)
                    begin
                        s_next.pr[i].psc = 2'd0;
                    end
                end
                ADDR_TBC:
                begin
                    wd = wmerge({25'h000_0000, s_reg.ie, s_reg.tbps, s_reg.mode, 1'b0, s_reg.en},
                                AXI_IN.wdata, AXI_IN.wstrb);
                    s_next.en = wd[TBC_EN];
                    s_next.mode = wd[TBC_MODE_LO +: 2];
                    s_next.tbps = wd[TBC_PS_LO +: 2];
                    s_next.ie = wd[TBC_IE];
                end
                ADDR_PER:
                begin
                    wd = wmerge({20'h0_0000, s_reg.per}, AXI_IN.wdata, AXI_IN.wstrb);
                    s_next.per = wd[11:0];
                end
                ADDR_DUTY0, ADDR_DUTY1, ADDR_DUTY2, ADDR_DUTY3:
                begin
                    wd = wmerge({18'h0_0000, s_reg.duty[2'(AXI_IN.awaddr[4:2] - 3'd3)]},
                                AXI_IN.wdata, AXI_IN.wstrb);
                    s_next.duty[2'(AXI_IN.awaddr[4:2] - 3'd3)] = wd[13:0];
                end
                ADDR_PAIR_MODE_BIT:
                begin
                    wd = wmerge({28'h000_0000, s_reg.pair_mode_bit}, AXI_IN.wdata, AXI_IN.wstrb);
                    s_next.pair_mode_bit = wd[3:0];
                end
                ADDR_OVS:
                begin
                    wd = wmerge({24'h00_0000, s_reg.ovs}, AXI_IN.wdata, AXI_IN.wstrb);
                    s_next.ovs = wd[7:0];
                end
                ADDR_OVV:
                begin
                    wd = wmerge({24'h00_0000, s_reg.ovv}, AXI_IN.wdata, AXI_IN.wstrb);
                    s_next.ovv = wd[7:0];
                end
                ADDR_STAT:
                begin
                    // write one clears; a same-cycle set below still wins
                    if (AXI_IN.wstrb[0] && AXI_IN.wdata[STAT_DONE])
                    begin
                        s_next.done = 1'b0;
                    end
                end
                default: s_next.axi.bresp = RESP_SLVERR;
            endcase
        end
        // register reads
        case (AXI_IN.araddr)
            ADDR_DTC: rd = {24'h00_0000, s_reg.dtc};
            ADDR_TBC: rd = {25'h000_0000, s_reg.ie, s_reg.tbps, s_reg.mode, 1'b0, s_reg.en};
            ADDR_PER: rd = {20'h0_0000, s_reg.per};
            ADDR_DUTY0, ADDR_DUTY1, ADDR_DUTY2, ADDR_DUTY3:
                rd = {18'h0_0000, s_reg.duty[2'(AXI_IN.araddr[4:2] - 3'd3)]};
            ADDR_PAIR_MODE_BIT: rd = {28'h000_0000, s_reg.pair_mode_bit};
            ADDR_OVS: rd = {24'h00_0000, s_reg.ovs};
            ADDR_OVV: rd = {24'h00_0000, s_reg.ovv};
            ADDR_STAT: rd = {4'h0, s_reg.tmr, s_reg.pins, 7'h00, s_reg.done};
            default: rd = 32'h0000_0000;
        endcase
        if (rd_go)
        begin
            s_next.axi.arready = 1'b1;
            s_next.rpend = 1'b1;
            s_next.axi.rdata = rd;
            s_next.axi.rresp = RESP_OKAY;
            if (AXI_IN.araddr > ADDR_STAT || AXI_IN.araddr[1:0] != 2'b00)
            begin
                s_next.axi.rresp = RESP_SLVERR;
            end
        end

        // time base: q phases run free, the timer steps once per divided cycle
        s_next.q = s_reg.q + 2'd1;
        s_next.en_q = s_reg.en;
        start = s_reg.en && !s_reg.en_q;
        tb_tick = s_reg.en && !start && s_reg.q == Q_LAST
            && s_reg.tdiv == tb_limit(s_reg.tbps);
        per_hit = tb_tick && s_reg.tmr == s_reg.per;
        if (!s_reg.en || start)
        begin
            s_next.tmr = 12'h000;
            s_next.tdiv = 6'h00;
        end
        else if (s_reg.q == Q_LAST)
        begin
            s_next.tdiv = tb_tick ? 6'h00 : s_reg.tdiv + 6'h01;
            if (tb_tick)
            begin
                s_next.tmr = per_hit ? 12'h000 : s_reg.tmr + 12'h001;
            end
        end

        // duty compares and dead-time pairs
        for (int i = 0; i < 4; i++)
        begin
            if (!s_reg.en)
            begin
                s_next.pr[i].cmp = 1'b0;
            end
            else if (start || (per_hit && s_reg.mode != MODE_SINGLE))
            begin
                s_next.pr[i].cmp = s_reg.duty[i] != 14'h0000;
            end
            else if (s_reg.tmr == s_reg.duty[i][13:2] && (s_reg.tbps == 2'b00 ?
                     s_reg.q == s_reg.duty[i][1:0] : (s_reg.q == 2'd0 && s_reg.tdiv == 6'h00)))
            begin
                s_next.pr[i].cmp = 1'b0;
            end
            // override feeds the dead-time unit, so dead time still applies
            s_next.pr[i].eff = s_reg.ovs[2*i+1] ? s_reg.pr[i].cmp : s_reg.ovv[2*i+1];
            if (s_reg.pair_mode_bit[i])
            begin
                // independent: one compare drives both pins, no dead time
                s_next.pr[i].busy = 1'b0;
                s_next.pr[i].odd = 1'b0;
                s_next.pr[i].even = 1'b0;
                s_next.pins[2*i+1] = s_next.pr[i].eff;
                s_next.pins[2*i] = s_reg.ovs[2*i] ? s_reg.pr[i].cmp : s_reg.ovv[2*i];
            end
            else
            begin
                // dead-time clock: osc/2 uses every other phase, else the match phase
                if (s_reg.dtc[DTC_PS_LO +: 2] == PS_DIV2)
                begin
                    dt_tick = s_reg.q[0] == s_reg.pr[i].ph[0];
                end
                else if (s_reg.q == s_reg.pr[i].ph)
                begin
                    dt_tick = s_reg.pr[i].psc == dt_limit(s_reg.dtc[DTC_PS_LO +: 2]);
                    s_next.pr[i].psc = (dt_tick || (wr_go && AXI_IN.awaddr == ADDR_DTC)) ? 2'd0
                        : s_reg.pr[i].psc + 2'd1;
                end
                else
                begin
                    dt_tick = 1'b0;
                end
                if (s_next.pr[i].eff != s_reg.pr[i].eff)
                begin
                    // edge: reload counter and clear the prescaler
                    s_next.pr[i].cnt = s_reg.dtc[5:0];
                    s_next.pr[i].psc = 2'd0;
                    s_next.pr[i].ph = s_reg.tbps == 2'b00 ? s_reg.q : 2'd0;
                    s_next.pr[i].busy = s_reg.dtc[5:0] != 6'h00;
                    if (s_next.pr[i].eff)
                    begin
                        s_next.pr[i].even = 1'b0;
                        s_next.pr[i].blank = 1'b0;
                        s_next.pr[i].odd = s_reg.dtc[5:0] == 6'h00;
                    end
                    else
                    begin
                        s_next.pr[i].odd = 1'b0;
                        // falling before the rise ended: blank the pair this period
                        s_next.pr[i].blank = s_reg.pr[i].busy;
                        s_next.pr[i].busy = s_reg.dtc[5:0] != 6'h00 && !s_reg.pr[i].busy;
                        s_next.pr[i].even = s_reg.dtc[5:0] == 6'h00;
                    end
                end
                else if (s_reg.pr[i].busy && dt_tick)
                begin
                    s_next.pr[i].cnt = s_reg.pr[i].cnt - 6'h01;
                    if (s_reg.pr[i].cnt == 6'h01)
                    begin
                        s_next.pr[i].busy = 1'b0;
                        s_next.pr[i].odd = s_reg.pr[i].eff;
                        s_next.pr[i].even = !s_reg.pr[i].eff && !s_reg.pr[i].blank;
                    end
                end
                s_next.pins[2*i+1] = s_next.pr[i].odd;
                s_next.pins[2*i] = s_next.pr[i].even;
            end
            // end of single pulse: every output inactive
            if (per_hit && s_reg.mode == MODE_SINGLE)
            begin
                s_next.pr[i].cmp = 1'b0;
                s_next.pr[i].eff = 1'b0;
                s_next.pr[i].busy = 1'b0;
                s_next.pr[i].odd = 1'b0;
                s_next.pr[i].even = 1'b0;
                s_next.pins[2*i+1] = 1'b0;
                s_next.pins[2*i] = 1'b0;
            end
        end
        // single pulse done: hardware clear of enable wins over a write
        if (per_hit && s_reg.mode == MODE_SINGLE)
        begin
            s_next.en = 1'b0;
            s_next.done = 1'b1;
            s_next.irq = s_reg.ie;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            s_reg <= '0;
            s_reg.dtc <= RST_DTC;
            s_reg.pair_mode_bit <= RST_PAIR_MODE_BIT;
            s_reg.ovs <= RST_OVS;
            s_reg.ovv <= RST_OVV;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign AXI_OUT = s_reg.axi;
    assign PWM_PINS = s_reg.pins;
    assign PULSE_DONE_IRQ = s_reg.irq;

    // ==========================================================
    // checks on pair 0 and the time base; a_psc_clear also covers pair 3, a_sp_stop all pins, a_sp_hold all duties, a_reset_mode all pairs
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    a_edge_reload: assert property (!s_reg.pair_mode_bit[0] && s_reg.pr[0].eff != $past(s_reg.pr[0].eff)
        && !$past(s_reg.pair_mode_bit[0]) |-> s_reg.pr[0].cnt == $past(s_reg.dtc[5:0]))
        else $error("dead-time counter not reloaded on edge");
    a_turnon_zero: assert property (!s_reg.pair_mode_bit[0] && $rose(s_reg.pr[0].odd)
        |-> s_reg.pr[0].cnt == 6'h00 && !s_reg.pr[0].busy)
        else $error("odd output turned on before dead time ran out");
    a_no_overlap: assert property (!s_reg.pair_mode_bit[0] |-> !(s_reg.pr[0].odd && s_reg.pr[0].even))
        else $error("complementary outputs active together");
    a_div2_spacing: assert property (s_reg.dtc[7:6] == PS_DIV2 && s_reg.pr[0].busy
        && $past(s_reg.pr[0].busy) && s_reg.pr[0].cnt == $past(s_reg.pr[0].cnt) - 6'h01
        |=> s_reg.pr[0].cnt == $past(s_reg.pr[0].cnt) || s_reg.pr[0].eff != $past(s_reg.pr[0].eff))
        else $error("osc/2 dead time stepped on adjacent cycles");
    a_psc_clear: assert property (wr_go && AXI_IN.awaddr == ADDR_DTC
        |=> s_reg.pr[0].psc == 2'd0 && s_reg.pr[3].psc == 2'd0)
        else $error("dead-time prescaler not cleared by control write");
    a_q1_step: assert property (s_reg.tbps != 2'b00 && s_reg.dtc[7:6] != PS_DIV2
        && s_reg.pr[0].busy && s_next.pr[0].cnt == s_reg.pr[0].cnt - 6'h01
        && s_next.pr[0].eff == s_reg.pr[0].eff && s_reg.pr[0].ph == 2'd0
        |-> s_reg.q == 2'd0)
        else $error("divided dead time stepped off Q1");
    a_indep_pair: assert property (s_reg.pair_mode_bit[0] && s_reg.ovs[1:0] == 2'b11 && !per_hit
        |=> PWM_PINS[1] == PWM_PINS[0])
        else $error("independent pair pins differ");
    a_sp_stop: assert property (per_hit && s_reg.mode == MODE_SINGLE
        |=> !s_reg.en && PWM_PINS == 8'h00 && s_reg.done ##1 s_reg.tmr == 12'h000)
        else $error("single pulse did not stop cleanly");
    a_sp_hold: assert property (per_hit && s_reg.mode == MODE_SINGLE && !wr_go
        |=> s_reg.per == $past(s_reg.per) && s_reg.duty == $past(s_reg.duty))
        else $error("period or duty changed after single pulse");
    a_reset_mode: assert property ($fell(RST) |-> s_reg.pair_mode_bit == RST_PAIR_MODE_BIT)
        else $error("pairs not complementary after reset");

    c_dead_done: cover property (s_reg.pr[0].busy ##1 !s_reg.pr[0].busy && s_reg.pr[0].odd);
    c_single_end: cover property (per_hit && s_reg.mode == MODE_SINGLE);
    c_blank: cover property ($rose(s_reg.pr[0].blank));
    c_bus_write: cover property (wr_go ##2 s_reg.axi.bvalid);
endmodule

// ==== dv/pdss_bridge_model.sv ====
// pdss_bridge_model: half-bridge switch legs hanging on the four pin pairs
// assumes active-high pins; the bench mirrors the pair mode into indep
`timescale 1ns/1ps
module pdss_bridge_model (
    input wire logic clk,
    input wire logic [7:0] pins,
    input wire logic [3:0] indep,
    output int shoot
);
    // ==========================================================
    // leg watch
    int hits = 0;
    assign shoot = hits;
    // both switches of a complementary leg on at once shorts the supply rail
    always @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!indep[i] && pins[2*i] && pins[2*i+1])
            begin
                hits <= hits + 1;
            end
        end
    end
endmodule

// ==== dv/pdss_stage_tb.sv ====
// pdss_stage_tb: self-checking bench for the dead-time and single-pulse stage
// assumes the axi4-lite slave timing and register map of pdss_pkg
`timescale 1ns/1ps
module pdss_stage_tb;
    import pdss_pkg::*;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    pdss_axi_in_t ai = '0;
    pdss_axi_out_t ao;
    logic [7:0] pins;
    logic irq;
    logic [3:0] indep = 4'h0;
    int shoot, miscompares = 0, total_checks = 0, cyc = 0, g, e, n;
    logic [31:0] rd;
    logic [1:0] rr;
    pdss_stage dut (.CORE_CLK(CORE_CLK), .RST(RST), .AXI_IN(ai), .AXI_OUT(ao),
        .PWM_PINS(pins), .PULSE_DONE_IRQ(irq));
    pdss_bridge_model load (.clk(CORE_CLK), .pins(pins), .indep(indep), .shoot(shoot));
    // ==========================================================
    // clock and hang guard
    always #5 CORE_CLK = ~CORE_CLK;
    // a stuck handshake would otherwise spin forever
    always @(posedge CORE_CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            final_report();
        end
    end
    // ==========================================================
    // shared tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, seen, exp);
        end
    endtask
    // write: address and data offered together, bready held until the answer
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        ai <= '{awaddr: a, awvalid: 1'b1, wdata: d, wstrb: 4'hF, wvalid: 1'b1,
            bready: 1'b1, default: '0};
        do @(posedge CORE_CLK); while (ao.awready !== 1'b1);
        ai <= '{bready: 1'b1, default: '0};
        do @(posedge CORE_CLK); while (ao.bvalid !== 1'b1);
        rr = ao.bresp;
        ai <= '0;
    endtask
    task axr(input logic [7:0] a);
        @(posedge CORE_CLK);
        ai <= '{araddr: a, arvalid: 1'b1, rready: 1'b1, default: '0};
        do @(posedge CORE_CLK); while (ao.arready !== 1'b1);
        ai <= '{rready: 1'b1, default: '0};
        do @(posedge CORE_CLK); while (ao.rvalid !== 1'b1);
        rd = ao.rdata;
        rr = ao.rresp;
        ai <= '0;
    endtask
    // cycles from pin f falling to pin o rising
    task gap(input int f, input int o);
        g = 0;
        while (pins[f] !== 1'b1) @(posedge CORE_CLK);
        while (pins[f] !== 1'b0) @(posedge CORE_CLK);
        while (pins[o] !== 1'b1 && g < 999)
        begin
            @(posedge CORE_CLK);
            g++;
        end
    endtask
    // stopped time base, 256-clock period, 160-clock duty on pair 0
    task setup(input logic [7:0] dtc);
        axw(ADDR_TBC, 32'h0000_0000);
        axw(ADDR_PER, 32'h0000_003F);
        axw(ADDR_DUTY0, 32'h0000_00A0);
        axw(ADDR_DTC, {24'h00_0000, dtc});
    endtask
    task final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task t_reset();
        axr(ADDR_DTC);
        chk(rd, 32'h0000_0000, "dtc reset");
        axr(ADDR_PAIR_MODE_BIT);
        chk(rd, 32'h0000_0000, "pair mode reset");
        axr(ADDR_OVS);
        chk(rd, 32'h0000_00FF, "override reset");
        axr(8'h3C);
        chk(32'(rr), 32'(RESP_SLVERR), "unmapped");
        axw(8'h3C, 32'h0000_0000);
        chk(32'(rr), 32'(RESP_SLVERR), "unmapped write");
        axw(ADDR_DTC, 32'h0000_00FF);
        chk(32'(rr), 32'(RESP_OKAY), "write okay");
        axr(ADDR_DTC);
        chk(rd, 32'h0000_00FF, "dtc fields");
        $display("test reset done");
    endtask
    task t_dead();
        for (int ps = 0; ps < 4; ps++)
        begin
            setup({ps[1:0], 6'd2});
            axw(ADDR_TBC, 32'h0000_0001);
            e = 2 << (ps + 1);
            gap(1, 0);
            chk(32'(g >= e && g <= e + 2), 32'h1, "fall gap");
            gap(0, 1);
            chk(32'(g >= e && g <= e + 2), 32'h1, "rise gap");
        end
        // prescaled time base: steps align to Q1, so up to three clocks shorter
        setup({2'b01, 6'd2});
        axw(ADDR_TBC, 32'h0000_0011);
        gap(1, 0);
        chk(32'(g >= 5 && g <= 8), 32'h1, "q1 fall gap");
        gap(0, 1);
        chk(32'(g >= 5 && g <= 8), 32'h1, "q1 rise gap");
        $display("test dead time done");
    endtask
    task t_blank();
        setup({2'b01, 6'd63});
        axw(ADDR_TBC, 32'h0000_0001);
        repeat (20) @(posedge CORE_CLK);
        n = 0;
        repeat (600) @(posedge CORE_CLK) n += (pins[1:0] !== 2'b00);
        chk(32'(n), 32'h0, "blanked pair");
        $display("test blanking done");
    endtask
    task t_indep();
        setup({2'b00, 6'd2});
        indep = 4'h1;
        axw(ADDR_PAIR_MODE_BIT, 32'h0000_0001);
        axw(ADDR_TBC, 32'h0000_0001);
        n = 0;
        g = 0;
        repeat (300) @(posedge CORE_CLK)
        begin
            n += (pins[1] !== pins[0]);
            g += (pins[1] === 1'b1);
        end
        chk(32'(n == 0 && g > 100), 32'h1, "pins follow duty");
        axw(ADDR_OVS, 32'h0000_00FE);
        for (int v = 1; v >= 0; v--)
        begin
            axw(ADDR_OVV, 32'(v));
            @(posedge CORE_CLK);
            n = 0;
            repeat (300) @(posedge CORE_CLK) n += (pins[0] !== v[0]);
            chk(32'(n), 32'h0, "forced pin");
        end
        axw(ADDR_TBC, 32'h0000_0000);
        axw(ADDR_OVS, 32'h0000_00FF);
        axw(ADDR_PAIR_MODE_BIT, 32'h0000_0000);
        indep = 4'h0;
        $display("test independent done");
    endtask
    task t_single();
        setup(8'h00);
        for (int k = 0; k < 2; k++)
        begin
            axw(ADDR_TBC, 32'h0000_0045);
            n = 0;
            while (pins[1] !== 1'b1 && n < 20)
            begin
                @(posedge CORE_CLK);
                n++;
            end
            chk(32'(pins[1]), 32'h1, "pulse start");
            while (irq !== 1'b1 && n < 400)
            begin
                @(posedge CORE_CLK);
                n++;
            end
            chk(32'(irq), 32'h1, "end irq");
            repeat (2) @(posedge CORE_CLK);
            chk(32'(pins[1:0]), 32'h0, "pins off");
            axr(ADDR_TBC);
            chk(32'(rd[TBC_EN]), 32'h0, "enable cleared");
            axr(ADDR_PER);
            chk(rd, 32'h0000_003F, "period kept");
            axr(ADDR_STAT);
            chk(32'(rd[STAT_DONE]), 32'h1, "done set");
            axw(ADDR_STAT, 32'h0000_0001);
            axr(ADDR_STAT);
            chk(32'(rd[STAT_DONE]), 32'h0, "done cleared");
        end
        $display("test single pulse done");
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (8) @(posedge CORE_CLK);
        RST <= 1'b0;
        t_reset();
        t_dead();
        t_blank();
        t_indep();
        t_single();
        chk(32'(shoot), 32'h0, "leg overlap");
        final_report();
    end
endmodule
